// file: rbx_regs.svh
// Register offsets, command field positions, reset values and cycle counts
// of the bit, shift and transfer executor. Included by its bare name.
`ifndef RBX_REGS_SVH
`define RBX_REGS_SVH

// ==========================================================================
// APB register byte offsets
`define RBX_OFF_CMD      8'h00
`define RBX_OFF_OPND     8'h04
`define RBX_OFF_STAT     8'h08
`define RBX_OFF_PC       8'h0c
`define RBX_OFF_SP       8'h10
`define RBX_OFF_RIDX     8'h14
`define RBX_OFF_RDAT     8'h18

// ==========================================================================
// Command word fields
`define RBX_CMD_OP_LSB   0
`define RBX_CMD_OP_W     6
`define RBX_CMD_RD_LSB   6
`define RBX_CMD_RD_W     5
`define RBX_CMD_BIT_LSB  11
`define RBX_CMD_BIT_W    3
`define RBX_CMD_PTR_LSB  14
`define RBX_CMD_MODE_LSB 16
`define RBX_CMD_W        18

// Status word fields
`define RBX_STAT_BUSY    0
`define RBX_STAT_FLG_LSB 8

// Flag register bit positions
`define RBX_FLG_C        0
`define RBX_FLG_Z        1
`define RBX_FLG_N        2
`define RBX_FLG_V        3
`define RBX_FLG_T        6
`define RBX_FLG_I        7

// ==========================================================================
// Reset values
`define RBX_RST_PC       16'h0000
`define RBX_RST_SP       16'h08ff
`define RBX_RST_FLG      8'h00

// Core cycles per operation class
`define RBX_CYC_SHORT    2'h1
`define RBX_CYC_MEM      2'h2
`define RBX_CYC_PMEM     2'h3

`endif

// file: rbx_pkg.sv
// Types of the bit, shift and transfer executor.
// Assumes rbx_regs.svh for the numeric field layout.
package rbx_pkg;

  typedef enum logic [5:0] {
    RBX_OP_NOP            = 6'h00,
    RBX_OP_BR_OVF_CLEAR   = 6'h01,
    RBX_OP_BR_IRQ_ON      = 6'h02,
    RBX_OP_BR_IRQ_OFF     = 6'h03,
    RBX_OP_IO_BIT_RAISE   = 6'h04,
    RBX_OP_IO_BIT_LOWER   = 6'h05,
    RBX_OP_LEFT_SHIFT     = 6'h06,
    RBX_OP_RIGHT_SHIFT    = 6'h07,
    RBX_OP_ROT_LEFT       = 6'h08,
    RBX_OP_ROT_RIGHT      = 6'h09,
    RBX_OP_SIGNED_SHIFT   = 6'h0a,
    RBX_OP_NIBBLE_SWAP    = 6'h0b,
    RBX_OP_FLAG_RAISE     = 6'h0c,
    RBX_OP_FLAG_LOWER     = 6'h0d,
    RBX_OP_BIT_TO_T       = 6'h0e,
    RBX_OP_T_TO_BIT       = 6'h0f,
    RBX_OP_POINTER_LOAD   = 6'h10,
    RBX_OP_DIRECT_LOAD    = 6'h11,
    RBX_OP_POINTER_WRITE  = 6'h12,
    RBX_OP_DIRECT_WRITE   = 6'h13,
    RBX_OP_PMEM_READ      = 6'h14,
    RBX_OP_STACK_DEPOSIT  = 6'h15,
    RBX_OP_STACK_RETRIEVE = 6'h16,
    RBX_OP_SLEEP          = 6'h17,
    RBX_OP_WDOG_RESTART   = 6'h18,
    RBX_OP_DEBUG_BREAK    = 6'h19
  } rbx_op_t;

  typedef enum logic [1:0] {
    RBX_PTR_X = 2'h0,
    RBX_PTR_Y = 2'h1,
    RBX_PTR_Z = 2'h2
  } rbx_ptr_t;

  typedef enum logic [1:0] {
    RBX_AM_PLAIN    = 2'h0,
    RBX_AM_POST_INC = 2'h1,
    RBX_AM_PRE_DEC  = 2'h2,
    RBX_AM_DISP     = 2'h3
  } rbx_amode_t;

  typedef enum logic [1:0] {
    RBX_ST_IDLE = 2'b01,
    RBX_ST_RUN  = 2'b10
  } rbx_state_t;

endpackage

// file: rbx_exec.sv
// Executor for branches on V and I, I/O bit writes, shifts, flag writes,
// T transfers, data and program memory transfers, stack and MCU control.
// Assumes APB on ref_clk, data memory and program memory answering one
// cycle after a read strobe and holding the data until the next strobe.
//
// Functional notes
// - Branch on V clear, I set or I clear; 1 cycle not taken, 2 taken.
// - I/O bit raise or lower writes one bit, keeps flags, takes 2 cycles.
// - Left shift moves bits up, zero into bit 0, updates Z C N V, 1 cycle.
// - Right shift moves bits down, zero into bit 7, updates Z C N V.
// - Rotates go through carry both ways, update Z C N V, one cycle.
// - Signed right shift keeps bit 7, updates Z C N V, one cycle.
// - Nibble swap exchanges halves in one cycle, flags untouched.
// - Flag raise or lower changes only the indexed flag, one cycle.
// - Bit to T and T to bit copies, one cycle each.
// - Pointer loads via X Y Z, two cycles, post-increment or pre-decrement.
// - Displaced loads read Y or Z plus offset, pointer unchanged, two cycles.
// - Direct load reads the given address in two cycles, no flags.
// - Pointer writes via X Y Z, two cycles, same update forms as loads.
// - Displaced writes at Y or Z plus offset, pointer unchanged.
// - Direct write to the given address in two cycles, no flags.
// - Program memory read at Z into a register, three cycles, optional Z+1.
// - Stack deposit and retrieve take two cycles, no flag effect.
// - No-op, sleep and watchdog restart take one cycle, pulse their units.
// - Debug break only signals the debug unit, no flag effect.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "rbx_regs.svh"

module rbx_exec #(
  parameter logic [15:0] RST_SP = `RBX_RST_SP
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Data memory
  output logic      [15:0] dm_addr,
  output logic      [7:0]  dm_wdata,
  output logic             dm_we,
  output logic             dm_re,
  input  wire logic [7:0]  dm_rdata,
  // Program memory
  output logic      [15:0] pm_addr,
  output logic             pm_re,
  input  wire logic [7:0]  pm_rdata,
  // I/O space and control units
  output logic      [5:0]  io_addr,
  output logic      [2:0]  io_bit,
  output logic             io_bit_raise,
  output logic             io_bit_lower,
  output logic             sleep_req,
  output logic             watchdog_restart,
  output logic             debug_break,
  output logic             busy
);

  // ========================================================================
  // State
  rbx_pkg::rbx_state_t state_q;
  rbx_pkg::rbx_op_t    op_q;
  rbx_pkg::rbx_amode_t mode_q;
  logic [7:0]  rf_q [32];
  logic [7:0]  flag_register_q;
  logic [15:0] pc_q, sp_q, opnd_q, ea_q, ptr_new_q;
  logic [4:0]  rd_q, ridx_q;
  logic [2:0]  bit_q;
  logic [1:0]  ptr_q, cnt_q;
  logic [`RBX_CMD_W-1:0] cmd_q;
  logic        first_q, taken_q;
  logic [7:0]  wd_q;
  logic [31:0] prdata_q;

  // ========================================================================
  // APB decode
  wire wr_acc   = psel & penable & pwrite;
  wire idle     = (state_q == rbx_pkg::RBX_ST_IDLE);
  wire run      = (state_q == rbx_pkg::RBX_ST_RUN);
  wire hit_cmd  = (paddr == `RBX_OFF_CMD);
  wire hit_opnd = (paddr == `RBX_OFF_OPND);
  wire hit_stat = (paddr == `RBX_OFF_STAT);
  wire hit_pc   = (paddr == `RBX_OFF_PC);
  wire hit_sp   = (paddr == `RBX_OFF_SP);
  wire hit_ridx = (paddr == `RBX_OFF_RIDX);
  wire hit_rdat = (paddr == `RBX_OFF_RDAT);
  wire hit_any  = hit_cmd | hit_opnd | hit_stat | hit_pc | hit_sp | hit_ridx | hit_rdat;
  wire issue    = wr_acc & hit_cmd & idle;
  wire sw_wr    = wr_acc & idle;

  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_q;

  wire [31:0] rd_mux =
    hit_cmd  ? {{(32-`RBX_CMD_W){1'b0}}, cmd_q} :
    hit_opnd ? {16'h0000, opnd_q} :
    hit_stat ? {16'h0000, flag_register_q, 7'h00, run} :
    hit_pc   ? {16'h0000, pc_q} :
    hit_sp   ? {16'h0000, sp_q} :
    hit_ridx ? {27'h0000000, ridx_q} :
    hit_rdat ? {24'h000000, rf_q[ridx_q]} : 32'h00000000;

  // ========================================================================
  // Command decode at issue
  wire [5:0] c_op_raw = pwdata[`RBX_CMD_OP_LSB +: `RBX_CMD_OP_W];
  wire rbx_pkg::rbx_op_t    c_op   = rbx_pkg::rbx_op_t'(c_op_raw);
  wire rbx_pkg::rbx_amode_t c_mode = rbx_pkg::rbx_amode_t'(pwdata[`RBX_CMD_MODE_LSB +: 2]);
  // Program memory reads always walk Z, whatever pointer field was written.
  wire [1:0] c_ptr = (c_op == rbx_pkg::RBX_OP_PMEM_READ) ? 2'h2 :
                     pwdata[`RBX_CMD_PTR_LSB +: 2];
  wire [4:0] c_rd  = pwdata[`RBX_CMD_RD_LSB +: `RBX_CMD_RD_W];

  // Pointer pairs are formed from r27:r26, r29:r28 and r31:r30.
  wire [15:0] ptr_x = {rf_q[27], rf_q[26]};
  wire [15:0] ptr_y = {rf_q[29], rf_q[28]};
  wire [15:0] ptr_z = {rf_q[31], rf_q[30]};
  wire [15:0] ptr_sel = (c_ptr == rbx_pkg::RBX_PTR_X) ? ptr_x :
                        (c_ptr == rbx_pkg::RBX_PTR_Y) ? ptr_y : ptr_z;
  wire [15:0] ptr_inc = ptr_sel + 16'h0001;
  wire [15:0] ptr_dec = ptr_sel - 16'h0001;
  wire [15:0] ptr_ea  = (c_mode == rbx_pkg::RBX_AM_PRE_DEC) ? ptr_dec :
                        (c_mode == rbx_pkg::RBX_AM_DISP) ?
                        ptr_sel + {10'h000, opnd_q[5:0]} : ptr_sel;
  wire [15:0] ptr_nxt = (c_mode == rbx_pkg::RBX_AM_POST_INC) ? ptr_inc :
                        (c_mode == rbx_pkg::RBX_AM_PRE_DEC) ? ptr_dec : ptr_sel;

  logic [15:0] c_ea;
  logic [1:0]  c_cyc;
  logic        c_taken;
  always_comb begin
    c_ea    = ptr_ea;
    c_cyc   = `RBX_CYC_SHORT;
    c_taken = 1'b0;
    unique case (c_op)
      rbx_pkg::RBX_OP_BR_OVF_CLEAR: c_taken = ~flag_register_q[`RBX_FLG_V];
      rbx_pkg::RBX_OP_BR_IRQ_ON:    c_taken = flag_register_q[`RBX_FLG_I];
      rbx_pkg::RBX_OP_BR_IRQ_OFF:   c_taken = ~flag_register_q[`RBX_FLG_I];
      rbx_pkg::RBX_OP_IO_BIT_RAISE,
      rbx_pkg::RBX_OP_IO_BIT_LOWER,
      rbx_pkg::RBX_OP_POINTER_LOAD,
      rbx_pkg::RBX_OP_POINTER_WRITE: c_cyc = `RBX_CYC_MEM;
      rbx_pkg::RBX_OP_DIRECT_LOAD,
      rbx_pkg::RBX_OP_DIRECT_WRITE: begin
        c_cyc = `RBX_CYC_MEM;
        c_ea  = opnd_q;
      end
      rbx_pkg::RBX_OP_PMEM_READ: begin
        c_cyc = `RBX_CYC_PMEM;
        c_ea  = ptr_z;
      end
      rbx_pkg::RBX_OP_STACK_DEPOSIT: begin
        c_cyc = `RBX_CYC_MEM;
        c_ea  = sp_q;
      end
      rbx_pkg::RBX_OP_STACK_RETRIEVE: begin
        c_cyc = `RBX_CYC_MEM;
        c_ea  = sp_q + 16'h0001;
      end
      default: c_cyc = `RBX_CYC_SHORT;
    endcase
    if (c_taken) begin
      c_cyc = `RBX_CYC_MEM;
    end
  end

  // ========================================================================
  // Shift unit and flag results
  wire [7:0] src   = rf_q[rd_q];
  wire       c_in  = flag_register_q[`RBX_FLG_C];
  logic [7:0] res;
  logic       c_out;
  always_comb begin
    res   = src;
    c_out = c_in;
    unique case (op_q)
      rbx_pkg::RBX_OP_LEFT_SHIFT:   {c_out, res} = {src, 1'b0};
      rbx_pkg::RBX_OP_RIGHT_SHIFT:  {res, c_out} = {1'b0, src};
      rbx_pkg::RBX_OP_ROT_LEFT:     {c_out, res} = {src, c_in};
      rbx_pkg::RBX_OP_ROT_RIGHT:    {res, c_out} = {c_in, src};
      rbx_pkg::RBX_OP_SIGNED_SHIFT: {res, c_out} = {src[7], src};
      rbx_pkg::RBX_OP_NIBBLE_SWAP:  res = {src[3:0], src[7:4]};
      rbx_pkg::RBX_OP_T_TO_BIT:     res[bit_q] = flag_register_q[`RBX_FLG_T];
      default:                      res = src;
    endcase
  end

  wire is_shift = (op_q == rbx_pkg::RBX_OP_LEFT_SHIFT) | (op_q == rbx_pkg::RBX_OP_RIGHT_SHIFT) |
                  (op_q == rbx_pkg::RBX_OP_ROT_LEFT) | (op_q == rbx_pkg::RBX_OP_ROT_RIGHT) |
                  (op_q == rbx_pkg::RBX_OP_SIGNED_SHIFT);
  wire is_load  = (op_q == rbx_pkg::RBX_OP_POINTER_LOAD) | (op_q == rbx_pkg::RBX_OP_DIRECT_LOAD) |
                  (op_q == rbx_pkg::RBX_OP_STACK_RETRIEVE);
  wire is_store = (op_q == rbx_pkg::RBX_OP_POINTER_WRITE) |
                  (op_q == rbx_pkg::RBX_OP_DIRECT_WRITE) |
                  (op_q == rbx_pkg::RBX_OP_STACK_DEPOSIT);
  wire is_ptr   = (op_q == rbx_pkg::RBX_OP_POINTER_LOAD) |
                  (op_q == rbx_pkg::RBX_OP_POINTER_WRITE) |
                  (op_q == rbx_pkg::RBX_OP_PMEM_READ);
  wire is_pmem  = (op_q == rbx_pkg::RBX_OP_PMEM_READ);
  wire is_br    = (op_q == rbx_pkg::RBX_OP_BR_OVF_CLEAR) | (op_q == rbx_pkg::RBX_OP_BR_IRQ_ON) |
                  (op_q == rbx_pkg::RBX_OP_BR_IRQ_OFF);
  wire last     = run & (cnt_q == 2'h0);
  wire go       = run & first_q;
  wire rd_wr    = last & (is_shift | is_load | is_pmem | (op_q == rbx_pkg::RBX_OP_NIBBLE_SWAP) |
                  (op_q == rbx_pkg::RBX_OP_T_TO_BIT));
  wire [7:0] rd_val = is_load ? dm_rdata : is_pmem ? pm_rdata : res;
  wire ptr_wr   = last & is_ptr & (mode_q == rbx_pkg::RBX_AM_POST_INC |
                  (mode_q == rbx_pkg::RBX_AM_PRE_DEC & ~is_pmem));
  wire [4:0] ptr_lo = 5'h1a + {2'h0, ptr_q, 1'b0};

  logic [7:0] flg_d;
  always_comb begin
    flg_d = flag_register_q;
    if (is_shift) begin
      flg_d[`RBX_FLG_C] = c_out;
      flg_d[`RBX_FLG_Z] = (res == 8'h00);
      flg_d[`RBX_FLG_N] = res[7];
      flg_d[`RBX_FLG_V] = res[7] ^ c_out;
    end
    if (op_q == rbx_pkg::RBX_OP_FLAG_RAISE) begin
      flg_d[bit_q] = 1'b1;
    end
    if (op_q == rbx_pkg::RBX_OP_FLAG_LOWER) begin
      flg_d[bit_q] = 1'b0;
    end
    if (op_q == rbx_pkg::RBX_OP_BIT_TO_T) begin
      flg_d[`RBX_FLG_T] = src[bit_q];
    end
  end

  // ========================================================================
  // Outputs towards memories and units
  assign busy             = run;
  assign dm_addr          = ea_q;
  assign dm_wdata         = wd_q;
  assign dm_re            = go & is_load;
  assign dm_we            = go & is_store;
  assign pm_addr          = ea_q;
  assign pm_re            = go & is_pmem;
  assign io_addr          = opnd_q[5:0];
  assign io_bit           = bit_q;
  assign io_bit_raise     = go & (op_q == rbx_pkg::RBX_OP_IO_BIT_RAISE);
  assign io_bit_lower     = go & (op_q == rbx_pkg::RBX_OP_IO_BIT_LOWER);
  assign sleep_req        = go & (op_q == rbx_pkg::RBX_OP_SLEEP);
  assign watchdog_restart = go & (op_q == rbx_pkg::RBX_OP_WDOG_RESTART);
  assign debug_break      = go & (op_q == rbx_pkg::RBX_OP_DEBUG_BREAK);

  // ========================================================================
  // Sequencer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= rbx_pkg::RBX_ST_IDLE;
      cnt_q   <= 2'h0;
      first_q <= 1'b0;
    end else begin
      first_q <= issue;
      unique case (state_q)
        rbx_pkg::RBX_ST_IDLE: if (issue) begin
          state_q <= rbx_pkg::RBX_ST_RUN;
          cnt_q   <= c_cyc - 2'h1;
        end
        rbx_pkg::RBX_ST_RUN: begin
          cnt_q <= cnt_q - 2'h1;
          if (last) state_q <= rbx_pkg::RBX_ST_IDLE;
        end
        default: state_q <= rbx_pkg::RBX_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      op_q      <= rbx_pkg::RBX_OP_NOP;
      mode_q    <= rbx_pkg::RBX_AM_PLAIN;
      cmd_q     <= '0;
      rd_q      <= 5'h00;
      bit_q     <= 3'h0;
      ptr_q     <= 2'h0;
      ea_q      <= 16'h0000;
      ptr_new_q <= 16'h0000;
      wd_q      <= 8'h00;
      taken_q   <= 1'b0;
    end else if (issue) begin
      op_q      <= c_op;
      mode_q    <= c_mode;
      cmd_q     <= pwdata[`RBX_CMD_W-1:0];
      rd_q      <= c_rd;
      bit_q     <= pwdata[`RBX_CMD_BIT_LSB +: `RBX_CMD_BIT_W];
      ptr_q     <= c_ptr;
      ea_q      <= c_ea;
      ptr_new_q <= ptr_nxt;
      wd_q      <= rf_q[c_rd];
      taken_q   <= c_taken;
    end
  end

  // ========================================================================
  // Architectural state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_register_q <= `RBX_RST_FLG;
      pc_q            <= `RBX_RST_PC;
      sp_q            <= RST_SP;
      opnd_q          <= 16'h0000;
      ridx_q          <= 5'h00;
      prdata_q        <= 32'h00000000;
    end else begin
      if (psel & ~penable & ~pwrite) prdata_q <= rd_mux;
      if (sw_wr & hit_opnd) opnd_q <= pwdata[15:0];
      if (sw_wr & hit_ridx) ridx_q <= pwdata[4:0];
      if (sw_wr & hit_stat) flag_register_q <= pwdata[`RBX_STAT_FLG_LSB +: 8];
      if (sw_wr & hit_pc) pc_q <= pwdata[15:0];
      if (sw_wr & hit_sp) sp_q <= pwdata[15:0];
      if (last) begin
        flag_register_q <= flg_d;
        pc_q <= (is_br & taken_q) ? pc_q + opnd_q + 16'h0001 : pc_q + 16'h0001;
        if (op_q == rbx_pkg::RBX_OP_STACK_DEPOSIT) sp_q <= sp_q - 16'h0001;
        if (op_q == rbx_pkg::RBX_OP_STACK_RETRIEVE) sp_q <= ea_q;
      end
    end
  end

  // The pointer update is written after the result, so it wins on overlap.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 32; i++) rf_q[i] <= 8'h00;
    end else begin
      if (sw_wr & hit_rdat) rf_q[ridx_q] <= pwdata[7:0];
      if (rd_wr) rf_q[rd_q] <= rd_val;
      if (ptr_wr) begin
        rf_q[ptr_lo]        <= ptr_new_q[7:0];
        rf_q[ptr_lo + 5'h1] <= ptr_new_q[15:8];
      end
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_two_cycle;
    go ##1 (busy && last) ##1 !busy;
  endsequence

  a_branch_target: assert property (last && is_br && taken_q |=>
    pc_q == $past(pc_q) + $past(opnd_q) + 16'h0001) else $error("branch target wrong");
  a_branch_len: assert property (issue && !c_taken && (c_op == rbx_pkg::RBX_OP_BR_IRQ_ON)
    |=> last ##1 !busy) else $error("untaken branch not one cycle");
  a_io_two_cycle: assert property (issue && (c_op == rbx_pkg::RBX_OP_IO_BIT_RAISE)
    |=> io_bit_raise ##0 s_two_cycle) else $error("io bit op not two cycles");
  a_left_shift: assert property (last && op_q == rbx_pkg::RBX_OP_LEFT_SHIFT |=>
    flag_register_q[`RBX_FLG_C] == $past(src[7]) && rf_q[$past(rd_q)] == {$past(src[6:0]), 1'b0})
    else $error("left shift wrong");
  a_swap_flags: assert property (last && op_q == rbx_pkg::RBX_OP_NIBBLE_SWAP |=>
    $stable(flag_register_q)) else $error("swap changed flags");
  a_flag_raise: assert property (last && op_q == rbx_pkg::RBX_OP_FLAG_RAISE |=>
    flag_register_q == ($past(flag_register_q) | (8'h01 << $past(bit_q))))
    else $error("flag raise touched other flags");
  a_load_two: assert property (issue && (c_op == rbx_pkg::RBX_OP_POINTER_LOAD)
    |=> dm_re ##0 s_two_cycle) else $error("load not two cycles");
  a_pmem_three: assert property (issue && (c_op == rbx_pkg::RBX_OP_PMEM_READ)
    |=> pm_re ##1 (busy && !last) ##1 last ##1 !busy) else $error("pmem read not three cycles");
  a_push_sp: assert property (last && op_q == rbx_pkg::RBX_OP_STACK_DEPOSIT |=>
    sp_q == $past(sp_q) - 16'h0001) else $error("stack pointer not decremented");

endmodule

// file: rbx_mem_model.sv
// Data memory and program memory model for the executor bench.
// Assumes read strobes are answered one edge later and the data then held.
`timescale 1ns/1ps

module rbx_mem_model (
  // Clock
  input  wire logic        ref_clk,
  // Data memory
  input  wire logic [15:0] dm_addr,
  input  wire logic [7:0]  dm_wdata,
  input  wire logic        dm_we,
  input  wire logic        dm_re,
  output logic      [7:0]  dm_rdata,
  // Program memory
  input  wire logic [15:0] pm_addr,
  input  wire logic        pm_re,
  output logic      [7:0]  pm_rdata
);
  logic [7:0] mem [256];

  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h3c;
    dm_rdata = 8'h00;
    pm_rdata = 8'h00;
  end

  // Only the low address byte decodes, so 16-bit addresses alias onto 256 bytes.
  always @(posedge ref_clk) begin
    if (dm_we) mem[dm_addr[7:0]] <= dm_wdata;
    if (dm_re) dm_rdata <= mem[dm_addr[7:0]];
    if (pm_re) pm_rdata <= pm_addr[7:0] ^ 8'h96;
  end
endmodule

// file: risc8_bitop_transfer_exec_tb.sv
// Self-checking bench of the executor, driven through its APB registers.
// Assumes rbx_mem_model answers the data and program memory ports.
`timescale 1ns/1ps

module risc8_bitop_transfer_exec_tb;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, err_q, busy;
  logic [7:0]  paddr, dm_wdata, dm_rdata, pm_rdata;
  logic [31:0] pwdata, prdata, rd_q;
  logic        dm_we, dm_re, pm_re, io_bit_raise, io_bit_lower;
  logic        sleep_req, watchdog_restart, debug_break;
  logic [15:0] dm_addr, pm_addr;
  logic [5:0]  io_addr;
  logic [2:0]  io_bit;
  logic [4:0]  tog_q;
  logic [8:0]  io_seen_q;
  int          error_cnt, comparisons, cyc, n;
  logic [7:0]  sh_d [6] = '{8'h02, 8'h40, 8'h03, 8'hc0, 8'hc0, 8'h18};
  logic [7:0]  sh_f [6] = '{8'h19, 8'h19, 8'h19, 8'h15, 8'h15, 8'h11};
  logic [7:0]  br_f [6] = '{8'h00, 8'h08, 8'h80, 8'h00, 8'h00, 8'h80};
  logic [5:0]  mc_o [4] = '{6'h00, 6'h17, 6'h18, 6'h19};

  rbx_exec dut (.ref_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata, .pm_addr, .pm_re,
    .pm_rdata, .io_addr, .io_bit, .io_bit_raise, .io_bit_lower, .sleep_req,
    .watchdog_restart, .debug_break, .busy);
  rbx_mem_model u_mem (.ref_clk, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata,
    .pm_addr, .pm_re, .pm_rdata);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Monitors
  always @(posedge ref_clk) begin
    tog_q <= tog_q ^ {debug_break, watchdog_restart, sleep_req, io_bit_lower, io_bit_raise};
    if (io_bit_raise || io_bit_lower) io_seen_q <= {io_addr, io_bit};
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      close_out();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      close_out();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chka(input logic [7:0] a, input string nm, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_q);
  endtask

  task automatic setr(input logic [4:0] i, input logic [7:0] v);
    apb(1'b1, 8'h14, {27'h0, i});
    apb(1'b1, 8'h18, {24'h0, v});
  endtask

  task automatic chkr(input logic [4:0] i, input string nm, input logic [7:0] e);
    apb(1'b1, 8'h14, {27'h0, i});
    chka(8'h18, nm, {24'h0, e});
  endtask

  // Starts one operation and counts the cycles that busy stays high.
  task automatic op(input logic [5:0] o, input logic [4:0] r, input logic [2:0] b,
                    input logic [1:0] p, input logic [1:0] m, input logic [31:0] d);
    apb(1'b1, 8'h04, d);
    apb(1'b1, 8'h00, {14'h0, m, p, b, r, o});
    #1;
    n = 0;
    while (busy === 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 20) begin
      error_cnt++;
      close_out();
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {tog_q, io_seen_q, error_cnt, comparisons, cyc} = '0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    chka(8'h10, "sp reset", 32'h08ff);
    chka(8'h1c, "unmapped data", 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err_q});
    for (int i = 0; i < 6; i++) begin
      setr(5'd1, 8'h81);
      apb(1'b1, 8'h08, 32'h1100);
      op(6'h06 + 6'(i), 5'd1, 3'd0, 2'd0, 2'd0, 32'h0);
      chk("shift cycles", 32'h1, 32'(n));
      chkr(5'd1, "shift data", sh_d[i]);
      chka(8'h08, "shift flags", {16'h0, sh_f[i], 8'h00});
    end
    $display("test shifts done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h08, 32'h0);
      op(6'h0c, 5'd0, 3'(i), 2'd0, 2'd0, 32'h0);
      chka(8'h08, "flag raise", 32'h100 << i);
      apb(1'b1, 8'h08, 32'hff00);
      op(6'h0d, 5'd0, 3'(i), 2'd0, 2'd0, 32'h0);
      chka(8'h08, "flag lower", 32'hff00 ^ (32'h100 << i));
      chk("flag cycles", 32'h1, 32'(n));
    end
    $display("test flags done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h0c, 32'h0100);
      apb(1'b1, 8'h08, {16'h0, br_f[i], 8'h00});
      op(6'h01 + 6'(i / 2), 5'd0, 3'd0, 2'd0, 2'd0, 32'hfff0);
      chk("branch cycles", (i % 2 == 0) ? 32'h2 : 32'h1, 32'(n));
      chka(8'h0c, "branch pc", (i % 2 == 0) ? 32'h00f1 : 32'h0101);
    end
    $display("test branches done");
    apb(1'b1, 8'h08, 32'h0);
    setr(5'd2, 8'h04);
    op(6'h0e, 5'd2, 3'd2, 2'd0, 2'd0, 32'h0);
    chka(8'h08, "bit to t", 32'h4000);
    op(6'h0f, 5'd2, 3'd7, 2'd0, 2'd0, 32'h0);
    chkr(5'd2, "t to bit", 8'h84);
    op(6'h04, 5'd0, 3'd3, 2'd0, 2'd0, 32'h15);
    chk("io cycles", 32'h2, 32'(n));
    op(6'h05, 5'd0, 3'd3, 2'd0, 2'd0, 32'h15);
    chk("io target", 32'h0ab, {23'h0, io_seen_q});
    for (int i = 0; i < 4; i++) begin
      op(mc_o[i], 5'd0, 3'd0, 2'd0, 2'd0, 32'h0);
      chk("mcu cycles", 32'h1, 32'(n));
    end
    chk("unit pulses", 32'h1f, {27'h0, tog_q});
    chka(8'h08, "flags kept", 32'h4000);
    $display("test bits and control done");
    setr(5'd5, 8'ha5);
    setr(5'd26, 8'h10);
    setr(5'd28, 8'h20);
    op(6'h12, 5'd5, 3'd0, 2'd0, 2'd1, 32'h0);
    chk("store cycles", 32'h2, 32'(n));
    chkr(5'd26, "x post inc", 8'h11);
    op(6'h10, 5'd6, 3'd0, 2'd0, 2'd2, 32'h0);
    chk("load cycles", 32'h2, 32'(n));
    chkr(5'd6, "x pre dec load", 8'ha5);
    chkr(5'd26, "x pre dec", 8'h10);
    op(6'h13, 5'd5, 3'd0, 2'd0, 2'd0, 32'h23);
    chk("direct store cycles", 32'h2, 32'(n));
    op(6'h10, 5'd7, 3'd0, 2'd1, 2'd3, 32'h3);
    chkr(5'd7, "y disp load", 8'ha5);
    op(6'h12, 5'd5, 3'd0, 2'd1, 2'd3, 32'h5);
    chkr(5'd28, "y kept", 8'h20);
    op(6'h11, 5'd7, 3'd0, 2'd0, 2'd0, 32'h24);
    chkr(5'd7, "direct load", 8'h18);
    op(6'h11, 5'd7, 3'd0, 2'd0, 2'd0, 32'h25);
    chkr(5'd7, "disp store", 8'ha5);
    op(6'h10, 5'd8, 3'd0, 2'd2, 2'd2, 32'h0);
    chkr(5'd8, "z wrap load", 8'hc3);
    chkr(5'd31, "z wrap", 8'hff);
    op(6'h14, 5'd8, 3'd0, 2'd2, 2'd1, 32'h0);
    chk("pmem cycles", 32'h3, 32'(n));
    chkr(5'd8, "pmem data", 8'h69);
    chkr(5'd30, "z inc wrap", 8'h00);
    op(6'h15, 5'd5, 3'd0, 2'd0, 2'd0, 32'h0);
    chk("push cycles", 32'h2, 32'(n));
    chka(8'h10, "sp push", 32'h08fe);
    op(6'h16, 5'd9, 3'd0, 2'd0, 2'd0, 32'h0);
    chkr(5'd9, "pop data", 8'ha5);
    chka(8'h10, "sp pop", 32'h08ff);
    op(6'h10, 5'd10, 3'd0, 2'd1, 2'd0, 32'h0);
    chkr(5'd10, "y plain load", 8'h1c);
    chkr(5'd28, "y plain kept", 8'h20);
    $display("test transfers done");
    close_out();
  end
endmodule
